// ===== compact_timer_pkg.sv
package compact_timer_pkg;

  // ********************************
  // Register map, byte addresses
  // ********************************
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] PIN_SELECT_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] CONTROL0_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] CONTROL1_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] COUNT_LOW_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] COUNT_HIGH_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] MATCH_A_LOW_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] MATCH_A_HIGH_OFS = 5'h18;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 5'h1C;

  // ********************************
  // Reset values and masks
  // ********************************
  localparam logic [7:0] PIN_SELECT_RST = 8'h00;
  localparam logic [7:0] CONTROL0_RST = 8'h00;
  localparam logic [7:0] CONTROL1_RST = 8'h00;
  localparam logic [7:0] PIN_SELECT_MASK = 8'hC7;
  localparam logic [7:0] CONTROL0_MASK = 8'hF8;
  localparam int COMPACT_PIN_BIT = 2;

  // ********************************
  // Prescaler and counter low-byte terminal counts
  // ********************************
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [3:0] HIGH_DIV16_LAST = 4'hF;
  localparam logic [5:0] HIGH_DIV64_LAST = 6'h3F;
  localparam logic [7:0] LOW_BYTE_LAST = 8'hFF;

  // ********************************
  // AXI responses
  // ********************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************
  // Field encodings
  // ********************************
  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0, CK_SYS = 3'h1, CK_HIGH_DIV16 = 3'h2, CK_HIGH_DIV64 = 3'h3,
    CK_SUB_A = 3'h4, CK_SUB_B = 3'h5, CK_EXT_RISE = 3'h6, CK_EXT_FALL = 3'h7
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0, MODE_UNDEF = 2'h1, MODE_PWM = 2'h2, MODE_TIMER = 2'h3
  } mode_t;

  // Compare mode: none/low/high/toggle; PWM mode: inactive/active/pwm/undefined
  typedef enum logic [1:0] {
    OF_NONE = 2'h0, OF_LOW = 2'h1, OF_HIGH = 2'h2, OF_TOGGLE = 2'h3
  } out_fn_t;

  typedef struct packed {
    logic counterPause;
    clk_sel_t clockSelect;
    logic counterEnable;
    logic [2:0] unused;
  } control0_t;

  typedef struct packed {
    mode_t modeField;
    out_fn_t outFunction;
    logic outInitialLevel;
    logic outPolarity;
    logic dutyPeriodSwap;
    logic clearSelect;
  } control1_t;

endpackage : compact_timer_pkg

// ===== compact_timer.sv
// What this block does
// - 16-bit up-counter on selected clock
// - P checks top byte, A all bits
// - separate requests for A and P matches
// - software only clears counter via enable rise
// - counter self-clears on overflow or match
// - pause holds count, resumes from it
// - three-bit select picks counter clock source
// - enable rise clears and starts; fall holds
// - enable rise restores initial output level
// - compare match drives pin low/high/toggle
// - PWM waveform appears on timer pin
// - unused timer pin released to others
// - pin-select bit 2 grants timer pin
// - match low-byte write lands in staging buffer
// - match high write also copies buffer low
// - high read captures low into buffer
// - counter read-only, match value read/write
// - control zero low bits read zero
// - mode field picks compare, PWM, timer
// - clear select picks A or P/overflow
// - out function: none, low, high, toggle
module compact_timer
  import compact_timer_pkg::*;
(
  input wire logic mclk, // 25 MHz system clock
  input wire logic arst_n, // Async reset, active low
  input wire logic highClk, // High clock, asynchronous
  input wire logic subClk, // Sub clock, asynchronous
  input wire logic extClockPin, // External count pin
  input wire logic [31:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [31:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  output logic irqMatchA, // Comparator A request pulse
  output logic irqMatchP, // Comparator P request pulse
  output logic timerPinOut, // Timer pin level
  output logic timerPinOwn // Timer owns the shared pin
);

  // ********************************
  // Register state
  // ********************************
  logic [7:0] pinSelect;
  control0_t ctl0;
  control1_t ctl1;
  logic [15:0] matchA;
  logic [7:0] period;
  logic [7:0] stageBuf;
  logic [15:0] cnt;
  logic enPrev;
  logic outLevel;

  // ********************************
  // Input synchronisers
  // ********************************
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] syncC;
  logic [1:0] sysDiv;
  logic [5:0] highDiv;

  // Two flops before use, third for edge detection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 3'h0;
      syncB <= 3'h0;
      syncC <= 3'h0;
    end else begin
      syncA <= {extClockPin, subClk, highClk};
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  logic highRise;
  logic subRise;
  logic extRise;
  logic extFall;
  assign highRise = syncB[0] & ~syncC[0];
  assign subRise = syncB[1] & ~syncC[1];
  assign extRise = syncB[2] & ~syncC[2];
  assign extFall = ~syncB[2] & syncC[2];

  // Free-running prescalers for the sys/4, high/16 and high/64 selections
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sysDiv <= 2'h0;
      highDiv <= 6'h0;
    end else begin
      sysDiv <= sysDiv + 2'h1;
      if (highRise) begin
        highDiv <= highDiv + 6'h1;
      end
    end
  end

  // ********************************
  // Count source selection
  // ********************************
  logic srcTick;

  // One-cycle tick per selected source edge
  always_comb begin
    unique case (ctl0.clockSelect)
      CK_SYS_DIV4: srcTick = (sysDiv == SYS_DIV4_LAST);
      CK_SYS: srcTick = 1'b1;
      CK_HIGH_DIV16: srcTick = highRise && (highDiv[3:0] == HIGH_DIV16_LAST);
      CK_HIGH_DIV64: srcTick = highRise && (highDiv == HIGH_DIV64_LAST);
      CK_SUB_A, CK_SUB_B: srcTick = subRise;
      CK_EXT_RISE: srcTick = extRise;
      CK_EXT_FALL: srcTick = extFall;
    endcase
  end

  // ********************************
  // Comparators and clear logic
  // ********************************
  logic enStart;
  logic tick;
  logic [7:0] periodLast;
  logic aHit;
  logic pHit;
  logic clearHit;

  assign enStart = ctl0.counterEnable && !enPrev;
  // Pause and disable both freeze the count
  assign tick = srcTick && ctl0.counterEnable && !ctl0.counterPause;
  // Period zero wraps to FF, i.e. plain 16-bit overflow
  assign periodLast = period - 8'h01;
  assign pHit = tick && (cnt[15:8] == periodLast) && (cnt[7:0] == LOW_BYTE_LAST);
  assign aHit = tick && (cnt == matchA);

  // PWM clears on its period comparator, others obey clear select
  always_comb begin
    if (ctl1.modeField == MODE_PWM) begin
      clearHit = ctl1.dutyPeriodSwap ? aHit : pHit;
    end else begin
      clearHit = ctl1.clearSelect ? aHit : pHit;
    end
  end

  // Counter: cleared on enable rise, else counts and self-clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0;
      enPrev <= 1'b0;
    end else begin
      enPrev <= ctl0.counterEnable;
      if (enStart) begin
        cnt <= 16'h0;
      end else if (clearHit) begin
        cnt <= 16'h0;
      end else if (tick) begin
        cnt <= cnt + 16'h1;
      end
    end
  end

  // Requests raised on every match, whatever clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irqMatchA <= 1'b0;
      irqMatchP <= 1'b0;
    end else begin
      irqMatchA <= aHit;
      irqMatchP <= pHit;
    end
  end

  // ********************************
  // Output pin
  // ********************************
  logic pwmActive;
  logic pwmLevel;

  // Duty from the comparator not used as period
  assign pwmActive = ctl1.dutyPeriodSwap ? (cnt[15:8] < period) : (cnt < matchA);

  always_comb begin
    unique case (ctl1.outFunction)
      OF_NONE: pwmLevel = ~ctl1.outInitialLevel;
      OF_LOW: pwmLevel = ctl1.outInitialLevel;
      OF_HIGH: pwmLevel = pwmActive ? ctl1.outInitialLevel : ~ctl1.outInitialLevel;
      OF_TOGGLE: pwmLevel = outLevel;
    endcase
  end

  // Compare-mode level: initial on enable rise, then per match
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      outLevel <= 1'b0;
    end else if (enStart) begin
      outLevel <= ctl1.outInitialLevel;
    end else if (aHit && ctl1.modeField == MODE_COMPARE) begin
      unique case (ctl1.outFunction)
        OF_NONE: outLevel <= outLevel;
        OF_LOW: outLevel <= 1'b0;
        OF_HIGH: outLevel <= 1'b1;
        OF_TOGGLE: outLevel <= ~outLevel;
      endcase
    end
  end

  // Pin driven only when enabled, selected and in an output mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timerPinOut <= 1'b0;
      timerPinOwn <= 1'b0;
    end else begin
      timerPinOwn <= pinSelect[COMPACT_PIN_BIT] && ctl0.counterEnable
        && (ctl1.modeField == MODE_COMPARE || ctl1.modeField == MODE_PWM);
      if (ctl1.modeField == MODE_PWM) begin
        timerPinOut <= pwmLevel ^ ctl1.outPolarity;
      end else begin
        timerPinOut <= outLevel ^ ctl1.outPolarity;
      end
    end
  end

  // ********************************
  // AXI4-Lite write channel
  // ********************************
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic wrHigh;
  logic [7:0] wrData;
  logic wrLane;
  logic wrCommit;
  logic next_awHeld;
  logic next_wHeld;

  assign wrCommit = awHeld && wHeld && !bvalid;
  assign next_awHeld = wrCommit ? 1'b0 : (awHeld || (awvalid && awready));
  assign next_wHeld = wrCommit ? 1'b0 : (wHeld || (wvalid && wready));

  // Address and data taken in either order, held till both here
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      wrAddr <= '0;
      wrHigh <= 1'b0;
      wrData <= 8'h0;
      wrLane <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awready <= !next_awHeld;
      wready <= !next_wHeld;
      if (awvalid && awready) begin
        wrAddr <= awaddr[ADDR_W-1:0];
        wrHigh <= (awaddr[31:ADDR_W] != '0);
      end
      if (wvalid && wready) begin
        wrData <= wdata[7:0];
        wrLane <= wstrb[0];
      end
    end
  end

  logic wrHit;
  logic wrEn;
  always_comb begin
    unique case (wrAddr)
      PIN_SELECT_OFS, CONTROL0_OFS, CONTROL1_OFS, COUNT_LOW_OFS, COUNT_HIGH_OFS,
      MATCH_A_LOW_OFS, MATCH_A_HIGH_OFS, PERIOD_OFS: wrHit = !wrHigh;
      default: wrHit = 1'b0;
    endcase
  end
  // Only the low lane carries register bits
  assign wrEn = wrCommit && wrHit && wrLane;

  // Response one cycle after both halves are held
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrCommit) begin
      bvalid <= 1'b1;
      bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ********************************
  // AXI4-Lite read channel
  // ********************************
  logic arTake;
  logic rdHit;
  logic [7:0] rdByte;
  logic next_rvalid;

  assign arTake = arvalid && arready;
  assign next_rvalid = arTake ? 1'b1 : (rvalid && !rready);

  always_comb begin
    rdHit = (araddr[31:ADDR_W] == '0);
    unique case (araddr[ADDR_W-1:0])
      PIN_SELECT_OFS: rdByte = pinSelect & PIN_SELECT_MASK;
      CONTROL0_OFS: rdByte = ctl0 & CONTROL0_MASK;
      CONTROL1_OFS: rdByte = ctl1;
      COUNT_LOW_OFS, MATCH_A_LOW_OFS: rdByte = stageBuf;
      COUNT_HIGH_OFS: rdByte = cnt[15:8];
      MATCH_A_HIGH_OFS: rdByte = matchA[15:8];
      PERIOD_OFS: rdByte = period;
      default: begin
        rdByte = 8'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  // Read answered the cycle after the address is taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      arready <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      arready <= !next_rvalid;
      if (arTake) begin
        rdata <= {24'h0, rdHit ? rdByte : 8'h0};
        rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ********************************
  // Software registers
  // ********************************

  // Control and compare storage; counter has no write path
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinSelect <= PIN_SELECT_RST;
      ctl0 <= control0_t'(CONTROL0_RST);
      ctl1 <= control1_t'(CONTROL1_RST);
      matchA <= 16'h0;
      period <= 8'h0;
    end else if (wrEn) begin
      unique case (wrAddr)
        PIN_SELECT_OFS: pinSelect <= wrData & PIN_SELECT_MASK;
        CONTROL0_OFS: ctl0 <= control0_t'(wrData & CONTROL0_MASK);
        CONTROL1_OFS: ctl1 <= control1_t'(wrData);
        MATCH_A_HIGH_OFS: matchA <= {wrData, stageBuf};
        PERIOD_OFS: period <= wrData;
        default: ;
      endcase
    end
  end

  // Staging buffer; a write beats a same-cycle read capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stageBuf <= 8'h0;
    end else if (wrEn && wrAddr == MATCH_A_LOW_OFS) begin
      stageBuf <= wrData;
    end else if (arTake && rdHit && araddr[ADDR_W-1:0] == COUNT_HIGH_OFS) begin
      stageBuf <= cnt[7:0];
    end else if (arTake && rdHit && araddr[ADDR_W-1:0] == MATCH_A_HIGH_OFS) begin
      stageBuf <= matchA[7:0];
    end
  end

  // ********************************
  // Assertions
  // ********************************
  enable_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    enStart |=> (cnt == 16'h0)) else $error("Counter not cleared on enable rise");

  pause_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (ctl0.counterPause && !enStart) |=> (cnt == $past(cnt))) else $error("Counter moved while paused");

  off_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !ctl0.counterEnable |=> $stable(cnt)) else $error("Counter moved while off");

  count_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (tick && !clearHit && !enStart) |=> (cnt == $past(cnt) + 16'h1)) else $error("Counter did not step");

  match_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (clearHit && !enStart) |=> (cnt == 16'h0)) else $error("Counter not cleared on match");

  request_p_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pHit |=> irqMatchP ##1 (!irqMatchP || $past(pHit))) else $error("Period request wrong");

  request_a_a: assert property (@(posedge mclk) disable iff (!arst_n)
    irqMatchA |-> $past(aHit)) else $error("Match request without match");

  compare_high_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (aHit && !enStart && ctl1.modeField == MODE_COMPARE && ctl1.outFunction == OF_HIGH)
      |=> outLevel) else $error("Compare high not applied");

  initial_level_a: assert property (@(posedge mclk) disable iff (!arst_n)
    enStart |=> (outLevel == $past(ctl1.outInitialLevel))) else $error("Initial level not restored");

  pin_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (!ctl0.counterEnable || ctl1.modeField == MODE_TIMER) |=> !timerPinOwn) else $error("Pin kept while unused");

  high_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (wrEn && wrAddr == MATCH_A_HIGH_OFS) |=> (matchA[7:0] == $past(stageBuf))) else $error("Buffer not copied");

  write_resp_a: assert property (@(posedge mclk) disable iff (!arst_n)
    wrCommit |=> bvalid) else $error("Write response missing");

  read_stable_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (rvalid && !rready) |=> (rvalid && $stable(rdata))) else $error("Read data changed early");

endmodule : compact_timer

// ===== compact_timer_partner.sv
module compact_timer_partner (
  output logic highClk, // High clock source
  output logic subClk, // Sub clock source
  output logic extClockPin // External count pin
);
  timeunit 1ns;
  timeprecision 1ns;

  // Free-running internal clocks, unrelated in phase to mclk
  // High clock kept below half of mclk, else the synchroniser aliases its edges
  initial begin
    highClk = 1'b0;
    forever #60 highClk = ~highClk;
  end
  initial begin
    subClk = 1'b0;
    forever #500 subClk = ~subClk;
  end

  // Event pin rests low between bursts
  initial extClockPin = 1'b0;

  // Levels held five mclk periods, well past the synchroniser
  // Edges placed off the mclk edges; total time stays a whole number of periods
  task automatic pulses(input int n);
    #10;
    repeat (n) begin
      #200 extClockPin = 1'b1;
      #200 extClockPin = 1'b0;
    end
    #190;
  endtask : pulses
endmodule : compact_timer_partner

// ===== compact_timer_bench.sv
module compact_timer_bench
  import compact_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic irqMatchA, irqMatchP, timerPinOut, timerPinOwn, highClk, subClk, extClockPin;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int nErrors = 0;
  int numChecks = 0;
  int irqA = 0;
  int cycleCount = 0;
  logic [26:0] addrTop = '0;

  compact_timer dut_u (.mclk(mclk), .arst_n(arst_n), .highClk(highClk), .subClk(subClk),
    .extClockPin(extClockPin), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irqMatchA(irqMatchA), .irqMatchP(irqMatchP),
    .timerPinOut(timerPinOut), .timerPinOwn(timerPinOwn));
  compact_timer_partner partnerU (.highClk(highClk), .subClk(subClk), .extClockPin(extClockPin));

  // ****************************
  // Clock, monitors and timeout
  // ****************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Match pulses last one cycle, so they are tallied rather than polled
  always @(posedge mclk) begin
    if (irqMatchA === 1'b1) irqA <= irqA + 1;
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      nErrors++;
      conclude();
    end
  end

  // ****************************
  // Bus and compare helpers
  // ****************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles

  // Address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    awaddr <= {addrTop, a};
    wdata <= {4{d}};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= {addrTop, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    check({14'h0, r}, {14'h0, RESP_OKAY});
  endtask : wr

  task automatic rdCheck(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    check({6'h0, r, d}, {6'h0, RESP_OKAY, e});
  endtask : rdCheck

  // High byte first, so the low byte comes from the same snapshot
  task automatic rdCount(input logic [15:0] e);
    rdCheck(COUNT_HIGH_OFS, e[15:8]);
    rdCheck(COUNT_LOW_OFS, e[7:0]);
  endtask : rdCount

  // ****************************
  // Scenarios
  // ****************************
  task automatic testRegisters;
    logic [1:0] r;
    logic [7:0] d;
    rdCheck(PIN_SELECT_OFS, 8'h00);
    rdCheck(CONTROL0_OFS, 8'h00);
    rdCheck(CONTROL1_OFS, 8'h00);
    rdCheck(PERIOD_OFS, 8'h00);
    axiWrite(5'h02, 8'h55, r);
    check({14'h0, r}, {14'h0, RESP_SLVERR});
    // Address bits above the map refused both ways, with no effect
    addrTop = 27'h1;
    axiWrite(CONTROL0_OFS, 8'h08, r);
    check({14'h0, r}, {14'h0, RESP_SLVERR});
    axiRead(CONTROL0_OFS, d, r);
    check({6'h0, r, d}, {6'h0, RESP_SLVERR, 8'h00});
    addrTop = '0;
    // Low lane strobe off: accepted but nothing lands
    wstrb <= 4'hE;
    wr(CONTROL1_OFS, 8'h5A);
    wstrb <= 4'hF;
    rdCheck(CONTROL1_OFS, 8'h00);
    rdCheck(CONTROL0_OFS, 8'h00);
    wr(CONTROL0_OFS, 8'h07);
    rdCheck(CONTROL0_OFS, 8'h00);
    wr(PIN_SELECT_OFS, 8'hFF);
    rdCheck(PIN_SELECT_OFS, 8'hC7);
    wr(PIN_SELECT_OFS, 8'h00);
    wr(COUNT_HIGH_OFS, 8'hAA);
    rdCount(16'h0000);
    $display("registers test finished");
  endtask : testRegisters

  task automatic testBuffer;
    wr(MATCH_A_LOW_OFS, 8'h34);
    wr(MATCH_A_HIGH_OFS, 8'h12);
    rdCheck(MATCH_A_HIGH_OFS, 8'h12);
    rdCheck(MATCH_A_LOW_OFS, 8'h34);
    wr(MATCH_A_LOW_OFS, 8'h56);
    rdCheck(MATCH_A_HIGH_OFS, 8'h12);
    rdCheck(MATCH_A_LOW_OFS, 8'h34);
    $display("buffer test finished");
  endtask : testBuffer

  task automatic testCounting;
    wr(CONTROL1_OFS, 8'hC0);
    wr(CONTROL0_OFS, 8'h68);
    partnerU.pulses(7);
    rdCount(16'd7);
    wr(CONTROL0_OFS, 8'hE8);
    partnerU.pulses(3);
    rdCount(16'd7);
    wr(CONTROL0_OFS, 8'h68);
    partnerU.pulses(2);
    rdCount(16'd9);
    wr(CONTROL0_OFS, 8'h78);
    partnerU.pulses(4);
    rdCount(16'd13);
    wr(CONTROL0_OFS, 8'h70);
    partnerU.pulses(2);
    rdCount(16'd13);
    wr(CONTROL0_OFS, 8'h78);
    rdCount(16'd0);
    $display("counting test finished");
  endtask : testCounting

  // Every output function once, matching at count 5 with clear on A
  task automatic testCompare;
    int base;
    logic init;
    logic expLevel;
    logic [1:0] fn;
    wr(PIN_SELECT_OFS, 8'h04);
    wr(MATCH_A_LOW_OFS, 8'h05);
    wr(MATCH_A_HIGH_OFS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      fn = 2'(i);
      init = (fn != OF_HIGH);
      expLevel = (fn == OF_NONE) ? init : (fn == OF_HIGH);
      wr(CONTROL0_OFS, 8'h60);
      wr(CONTROL1_OFS, {2'b00, fn, init, 3'b001});
      wr(CONTROL0_OFS, 8'h68);
      cycles(3);
      check({15'h0, timerPinOut}, {15'h0, init});
      check({15'h0, timerPinOwn}, 16'h0001);
      base = irqA;
      partnerU.pulses(6);
      check(16'(irqA - base), 16'd1);
      check({15'h0, timerPinOut}, {15'h0, expLevel});
      rdCount(16'd0);
    end
    wr(CONTROL0_OFS, 8'h60);
    wr(CONTROL0_OFS, 8'h68);
    cycles(3);
    check({15'h0, timerPinOut}, 16'h0001);
    wr(PIN_SELECT_OFS, 8'h00);
    cycles(3);
    check({15'h0, timerPinOwn}, 16'h0000);
    $display("compare test finished");
  endtask : testCompare

  task automatic waitIrqP(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (irqMatchP !== 1'b1 && n < 4000);
  endtask : waitIrqP

  task automatic testPeriod;
    int n;
    wr(CONTROL0_OFS, 8'h00);
    wr(CONTROL1_OFS, 8'hC0);
    wr(CONTROL0_OFS, 8'h18);
    for (int p = 1; p < 3; p++) begin
      wr(PERIOD_OFS, 8'(p));
      waitIrqP(n);
      waitIrqP(n);
      check(16'(n), 16'(256 * p));
    end
    // Same period on the sys/4 source: four clocks per count
    wr(CONTROL0_OFS, 8'h08);
    waitIrqP(n);
    waitIrqP(n);
    check(16'(n), 16'(4 * 256 * 2));
    $display("period test finished");
  endtask : testPeriod

  // Duty 5 of a 256-count period, two whole periods sampled, then inverted
  task automatic testPwm;
    int highs;
    wr(PERIOD_OFS, 8'h01);
    wr(PIN_SELECT_OFS, 8'h04);
    for (int pol = 0; pol < 2; pol++) begin
      wr(CONTROL0_OFS, 8'h00);
      wr(CONTROL1_OFS, (pol != 0) ? 8'hAC : 8'hA8);
      wr(CONTROL0_OFS, 8'h18);
      cycles(300);
      highs = 0;
      repeat (512) begin
        @(posedge mclk);
        if (timerPinOut === 1'b1) highs++;
      end
      check(16'(highs), (pol != 0) ? 16'd502 : 16'd10);
      check({15'h0, timerPinOwn}, 16'h0001);
    end
    $display("pwm test finished");
  endtask : testPwm

  task automatic conclude;
    $display("checks %0d, mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    arst_n = 1'b0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    wstrb = 4'hF;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    testRegisters();
    testBuffer();
    testCounting();
    testCompare();
    testPeriod();
    testPwm();
    conclude();
  end
endmodule : compact_timer_bench
